// file: src/iop_ports.sv
// Input port and bidirectional port logic with option register and AXI4-Lite access.
// How it works
// - Edge-select bit resets to 0 for falling edge; 1 selects rising edge.
// - First-port bypass bit 0 takes request edges from debounced inputs; 1 takes them from undebounced inputs.
// - Third-port bypass bit only drives THIRD_DEBOUNCE_BYPASS_OUT; pin 2 stays debounced here.
// - Watchdog-disable bit resets 0 keeping watchdog on; 1 turns time-out off.
// - Debounced input accepts level held over two consecutive debounce tap edges.
// - Input status read returns current pin levels, no latching or debouncing.
// - Debounced pins 0, 1, 2 drive the three branch test variables.
// - Input pin 3 also goes out as the event counter pulse input.
// - Each input has a mask bit; edges request only when mask is 1.
// - Request flags clear on reset and on read; read clears summary flag.
// - Request bit n is the latched flag of input pin n, reset 0.
// - Direction bit 0 makes pin high impedance; 1 drives the data bit.
// - Data read returns pins in input mode; write updates driven data.
// - Reset clears all direction bits so every bidirectional pin is input, except pin 0 while the buzzer is enabled.
// - Bidirectional pin 0 can carry the buzzer tone when buzzer selects it.
// - With read blocking, driving pins read back data register, not pin.
// - With sleep tristate option, driven outputs release during sleep.
`timescale 1ns/1ps
module iop_ports
  import iop_pkg::*;
#(
  parameter int          FAST_DIV                = FAST_TAP_DIV,
  parameter int          SLOW_DIV                = SLOW_TAP_DIV,
  parameter bit          USE_SLOW_TAP            = 1'b0,
  parameter logic [3:0]  READ_BLOCK_WHEN_DRIVING = 4'h0,
  parameter logic [3:0]  SLEEP_TRISTATE_OPTION   = 4'h0
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
  input  wire logic              AXI_AWVALID_IN,
  output logic                   AXI_AWREADY_OUT,
  input  wire logic [31:0]       AXI_WDATA_IN,
  input  wire logic [3:0]        AXI_WSTRB_IN,
  input  wire logic              AXI_WVALID_IN,
  output logic                   AXI_WREADY_OUT,
  output logic [1:0]             AXI_BRESP_OUT,
  output logic                   AXI_BVALID_OUT,
  input  wire logic              AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
  input  wire logic              AXI_ARVALID_IN,
  output logic                   AXI_ARREADY_OUT,
  output logic [31:0]            AXI_RDATA_OUT,
  output logic [1:0]             AXI_RRESP_OUT,
  output logic                   AXI_RVALID_OUT,
  input  wire logic              AXI_RREADY_IN,
  input  wire logic [3:0]        INPUT_PIN_IN,
  input  wire logic [3:0]        BIDIR_PIN_IN,
  output logic [3:0]             BIDIR_PIN_OUT,
  output logic [3:0]             BIDIR_PIN_OE_N_OUT,
  input  wire logic              BUZZER_ENABLE_IN,
  input  wire logic              BUZZER_TONE_IN,
  input  wire logic              SLEEP_IN,
  output logic                   BRANCH_TEST_ONE_OUT,
  output logic                   BRANCH_TEST_TWO_OUT,
  output logic                   BRANCH_TEST_THREE_OUT,
  output logic                   EVENT_COUNTER_PIN_OUT,
  output logic                   INPUT_GROUP_SUMMARY_OUT,
  output logic                   SUMMARY_CLEAR_OUT,
  output logic                   RISING_EDGE_SELECT_OUT,
  output logic                   THIRD_DEBOUNCE_BYPASS_OUT,
  output logic                   WATCHDOG_DISABLE_OUT,
  output logic                   IRQ_OUT
);

  localparam int TAP_DIV = USE_SLOW_TAP ? SLOW_DIV : FAST_DIV;

  generate
    if (TAP_DIV < 2 || TAP_DIV > 65536 || ADDR_W < 5) begin : g_bad_param
      $error("iop_ports: tap division or address width out of range.");
    end
  endgenerate

  logic [3:0]  option_reg;
  logic [3:0]  in_irq_mask;
  logic [3:0]  in_irq_req;
  logic [3:0]  next_in_irq_req;
  logic [3:0]  bidir_data;
  logic [3:0]  bidir_dir;
  logic [3:0]  int_status;
  logic [3:0]  int_mask;
  logic [3:0]  in_meta;
  logic [3:0]  in_sync;
  logic [3:0]  bd_meta;
  logic [3:0]  bd_sync;
  logic [3:0]  deb_sample;
  logic [3:0]  deb_level;
  logic [3:0]  edge_src;
  logic [3:0]  edge_prev;
  logic [3:0]  edge_hit;
  logic [3:0]  req_set;
  logic [3:0]  bidir_read;
  logic [3:0]  drive;
  logic [15:0] tap_cnt;
  logic        tap_tick;
  logic        aw_held;
  logic        w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_lane;
  logic        ar_fire;
  logic        req_read_clr;
  logic [31:0] next_rdata;
  logic        rd_hit;
  logic        wr_hit;

  // Both pin groups come from outside the clock domain.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
      bd_meta <= 4'h0;
      bd_sync <= 4'h0;
    end else begin
      in_meta <= INPUT_PIN_IN;
      in_sync <= in_meta;
      bd_meta <= BIDIR_PIN_IN;
      bd_sync <= bd_meta;
    end
  end

  // Prescaler tap used as the debounce clock, one enable pulse per tap period.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      tap_cnt  <= 16'h0000;
      tap_tick <= 1'b0;
    end else if (tap_cnt == 16'(TAP_DIV - 1)) begin
      tap_cnt  <= 16'h0000;
      tap_tick <= 1'b1;
    end else begin
      tap_cnt  <= tap_cnt + 16'h0001;
      tap_tick <= 1'b0;
    end
  end

  // Debouncers: the new level must match at two consecutive tap edges.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_deb
      always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
          deb_sample[gi] <= 1'b0;
          deb_level[gi]  <= 1'b0;
        end else if (tap_tick) begin
          deb_sample[gi] <= in_sync[gi];
          if (deb_sample[gi] == in_sync[gi]) begin
            deb_level[gi] <= in_sync[gi];
          end
        end
      end
    end
  endgenerate

  // A toggle of the bypass bit may itself look like an edge; software masks first.
  always_comb begin
    edge_src = option_reg[OPT_FIRST_BYPASS] ? in_sync : deb_level;
    if (option_reg[OPT_RISING_EDGE]) begin
      edge_hit = edge_src & ~edge_prev;
    end else begin
      edge_hit = ~edge_src & edge_prev;
    end
    req_set         = edge_hit & in_irq_mask;
    // A new request in the clearing read cycle survives.
    next_in_irq_req = (in_irq_req & ~{PORT_W{req_read_clr}}) | req_set;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      edge_prev               <= 4'h0;
      in_irq_req              <= IN_IRQ_REQ_RESET;
      INPUT_GROUP_SUMMARY_OUT <= 1'b0;
      SUMMARY_CLEAR_OUT       <= 1'b0;
    end else begin
      edge_prev               <= edge_src;
      in_irq_req              <= next_in_irq_req;
      INPUT_GROUP_SUMMARY_OUT <= |next_in_irq_req;
      SUMMARY_CLEAR_OUT       <= req_read_clr;
    end
  end

  // Fixed routing of the input port to the CPU and the event counter.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      BRANCH_TEST_ONE_OUT   <= 1'b0;
      BRANCH_TEST_TWO_OUT   <= 1'b0;
      BRANCH_TEST_THREE_OUT <= 1'b0;
      EVENT_COUNTER_PIN_OUT <= 1'b0;
    end else begin
      BRANCH_TEST_ONE_OUT   <= deb_level[0];
      BRANCH_TEST_TWO_OUT   <= deb_level[1];
      BRANCH_TEST_THREE_OUT <= deb_level[2];
      EVENT_COUNTER_PIN_OUT <= in_sync[3];
    end
  end

  assign RISING_EDGE_SELECT_OUT    = option_reg[OPT_RISING_EDGE];
  assign THIRD_DEBOUNCE_BYPASS_OUT = option_reg[OPT_THIRD_BYPASS];
  assign WATCHDOG_DISABLE_OUT      = option_reg[OPT_WATCHDOG_DIS];

  // Pin drivers; the buzzer outranks the direction bit on pin 0.
  always_comb begin
    drive    = bidir_dir;
    drive[0] = bidir_dir[0] | BUZZER_ENABLE_IN;
    if (SLEEP_IN) begin
      drive = drive & ~SLEEP_TRISTATE_OPTION;
    end
    // Blocked driving pins give the data latch, so software keeps a RAM image.
    bidir_read = (bidir_dir & READ_BLOCK_WHEN_DRIVING & bidir_data) |
                 (~(bidir_dir & READ_BLOCK_WHEN_DRIVING) & bd_sync);
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      BIDIR_PIN_OUT      <= 4'h0;
      BIDIR_PIN_OE_N_OUT <= 4'hF;
    end else begin
      BIDIR_PIN_OUT      <= {bidir_data[3:1], BUZZER_ENABLE_IN ? BUZZER_TONE_IN : bidir_data[0]};
      BIDIR_PIN_OE_N_OUT <= ~drive;
    end
  end

  // AXI4-Lite write side: address and data are held until both are present.
  assign AXI_AWREADY_OUT = !aw_held && !AXI_BVALID_OUT;
  assign AXI_WREADY_OUT  = !w_held && !AXI_BVALID_OUT;
  assign do_write        = aw_held && w_held && !AXI_BVALID_OUT;
  assign wr_lane         = do_write && w_strb[0];

  always_comb begin
    case (aw_addr)
      OFF_OPTION, OFF_IN_STATUS, OFF_IN_IRQ_REQ, OFF_IN_IRQ_MASK,
      OFF_BIDIR_DATA, OFF_BIDIR_DIR, OFF_INT_STATUS, OFF_INT_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= '0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT  <= RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_held <= 1'b1;
        aw_addr <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_held <= 1'b1;
        w_data <= AXI_WDATA_IN;
        w_strb <= AXI_WSTRB_IN;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // Software-written registers, one concern per block.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      option_reg  <= OPTION_RESET;
      in_irq_mask <= IN_IRQ_MASK_RESET;
      bidir_data  <= BIDIR_DATA_RESET;
      bidir_dir   <= BIDIR_DIR_RESET;
      int_mask    <= INT_MASK_RESET;
    end else if (wr_lane) begin
      case (aw_addr)
        OFF_OPTION:      option_reg  <= w_data[3:0];
        OFF_IN_IRQ_MASK: in_irq_mask <= w_data[3:0];
        OFF_BIDIR_DATA:  bidir_data  <= w_data[3:0];
        OFF_BIDIR_DIR:   bidir_dir   <= w_data[3:0];
        OFF_INT_MASK:    int_mask    <= w_data[3:0];
        default: ;
      endcase
    end
  end

  // Sticky event bits: a new request sets, a written one clears, and the set wins.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      int_status <= INT_STATUS_RESET;
      IRQ_OUT    <= 1'b0;
    end else begin
      if (wr_lane && aw_addr == OFF_INT_STATUS) begin
        int_status <= (int_status & ~w_data[3:0]) | req_set;
      end else begin
        int_status <= int_status | req_set;
      end
      IRQ_OUT <= |(int_status & int_mask);
    end
  end

  // AXI4-Lite read side; reading the request register clears it.
  assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;
  assign ar_fire         = AXI_ARVALID_IN && AXI_ARREADY_OUT;
  assign req_read_clr    = ar_fire && AXI_ARADDR_IN == OFF_IN_IRQ_REQ;

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (AXI_ARADDR_IN)
      OFF_OPTION:      next_rdata[3:0] = option_reg;
      OFF_IN_STATUS:   next_rdata[3:0] = in_sync;
      OFF_IN_IRQ_REQ:  next_rdata[3:0] = in_irq_req;
      OFF_IN_IRQ_MASK: next_rdata[3:0] = in_irq_mask;
      OFF_BIDIR_DATA:  next_rdata[3:0] = bidir_read;
      OFF_BIDIR_DIR:   next_rdata[3:0] = bidir_dir;
      OFF_INT_STATUS:  next_rdata[3:0] = int_status;
      OFF_INT_MASK:    next_rdata[3:0] = int_mask;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT  <= 32'h0000_0000;
      AXI_RRESP_OUT  <= RESP_OKAY;
    end else if (ar_fire) begin
      AXI_RVALID_OUT <= 1'b1;
      AXI_RDATA_OUT  <= next_rdata;
      AXI_RRESP_OUT  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
      AXI_RVALID_OUT <= 1'b0;
    end
  end

  // Checks kept beside the logic they guard.
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_falling_sets;
    (!option_reg[OPT_RISING_EDGE] && in_irq_mask[0] && edge_prev[0] && !edge_src[0]) |=> in_irq_req[0];
  endproperty
  a_falling_sets: assert property (p_falling_sets) else $error("Falling edge did not set the flag.");
  property p_rising_ignored;
    (option_reg[OPT_RISING_EDGE] && !in_irq_req[1] && !(edge_src[1] && !edge_prev[1]))
      |=> !in_irq_req[1];
  endproperty
  a_rising_ignored: assert property (p_rising_ignored) else $error("Flag set without a rising edge.");
  property p_bypass_direct;
    option_reg[OPT_FIRST_BYPASS] |-> edge_src == in_sync;
  endproperty
  a_bypass_direct: assert property (p_bypass_direct) else $error("Bypass did not select direct input.");
  property p_reset_options;
    $fell(SYS_RST_IN) |-> option_reg == 4'h0 && !WATCHDOG_DISABLE_OUT && !THIRD_DEBOUNCE_BYPASS_OUT;
  endproperty
  a_reset_options: assert property (p_reset_options) else $error("Options not clear after reset.");
  property p_deb_on_tick;
    $changed(deb_level) |-> $past(tap_tick) && $past(deb_sample) == deb_level;
  endproperty
  a_deb_on_tick: assert property (p_deb_on_tick) else $error("Debounced level moved off a tap edge.");
  property p_status_read;
    (ar_fire && AXI_ARADDR_IN == OFF_IN_STATUS) |=> AXI_RVALID_OUT && AXI_RDATA_OUT[3:0] == $past(in_sync);
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status read not the pin level.");
  property p_masked_quiet;
    (!in_irq_mask[2] && !in_irq_req[2]) |=> !in_irq_req[2];
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("Masked pin raised a request.");
  property p_read_clears;
    (req_read_clr && req_set == 4'h0) |=> in_irq_req == 4'h0 && !INPUT_GROUP_SUMMARY_OUT && SUMMARY_CLEAR_OUT;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Read did not clear requests.");
  property p_summary;
    INPUT_GROUP_SUMMARY_OUT == (|in_irq_req);
  endproperty
  a_summary: assert property (p_summary) else $error("Summary out of step with flags.");
  property p_input_hiz;
    (!bidir_dir[3] && !$past(bidir_dir[3])) |-> BIDIR_PIN_OE_N_OUT[3];
  endproperty
  a_input_hiz: assert property (p_input_hiz) else $error("Input-mode pin is driven.");
  property p_dir_reset;
    $fell(SYS_RST_IN) |-> bidir_dir == 4'h0 ##1 BIDIR_PIN_OE_N_OUT[3:1] == 3'h7;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("Direction bits not clear after reset.");

  c_flag_set:   cover property (req_set != 4'h0);
  c_read_clear: cover property (req_read_clr && in_irq_req != 4'h0);
  c_irq:        cover property ($rose(IRQ_OUT));
  c_drive:      cover property (BIDIR_PIN_OE_N_OUT != 4'hF);

endmodule // iop_ports

// file: common/iop_pkg.sv
// Shared constants for the input and bidirectional port block.
package iop_pkg;
  localparam int          PORT_W             = 4;
  localparam int          ADDR_W             = 8;
  // Register byte offsets.
  localparam logic [7:0]  OFF_OPTION         = 8'h00;
  localparam logic [7:0]  OFF_IN_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_IN_IRQ_REQ     = 8'h08;
  localparam logic [7:0]  OFF_IN_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  OFF_BIDIR_DATA     = 8'h10;
  localparam logic [7:0]  OFF_BIDIR_DIR      = 8'h14;
  localparam logic [7:0]  OFF_INT_STATUS     = 8'h18;
  localparam logic [7:0]  OFF_INT_MASK       = 8'h1C;
  // Option register field positions.
  localparam int          OPT_WATCHDOG_DIS   = 0;
  localparam int          OPT_FIRST_BYPASS   = 1;
  localparam int          OPT_THIRD_BYPASS   = 2;
  localparam int          OPT_RISING_EDGE    = 3;
  // Reset values.
  localparam logic [3:0]  OPTION_RESET       = 4'h0;
  localparam logic [3:0]  IN_IRQ_REQ_RESET   = 4'h0;
  localparam logic [3:0]  IN_IRQ_MASK_RESET  = 4'h0;
  localparam logic [3:0]  BIDIR_DATA_RESET   = 4'h0;
  localparam logic [3:0]  BIDIR_DIR_RESET    = 4'h0;
  localparam logic [3:0]  INT_STATUS_RESET   = 4'h0;
  localparam logic [3:0]  INT_MASK_RESET     = 4'h0;
  // Debounce clock taps as system clock divisions.
  localparam int          FAST_TAP_DIV       = 32;
  localparam int          SLOW_TAP_DIV       = 256;
  // Bus responses.
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
endpackage

// file: testbench/iop_pin_partner.sv
// Switches and loads wired to the input and bidirectional port pins.
`timescale 1ns/1ps
module iop_pin_partner (
  input  wire logic [3:0] switch_level_in,
  input  wire logic [3:0] ext_drive_in,
  input  wire logic [3:0] clamp_low_in,
  input  wire logic [3:0] pin_drive_in,
  input  wire logic [3:0] pin_oe_n_in,
  output logic [3:0]      input_pin_out,
  output logic [3:0]      bidir_pin_out
);
  // A released pin follows the outside circuit; a clamped pin models a shorted load that wins over the driver.
  always_comb begin
    input_pin_out = switch_level_in;
    bidir_pin_out = ((pin_drive_in & ~pin_oe_n_in) | (ext_drive_in & pin_oe_n_in)) & ~clamp_low_in;
  end
endmodule // iop_pin_partner

// file: testbench/iop_ports_bench.sv
// Self-checking bench for the input and bidirectional port block.
`timescale 1ns/1ps
module iop_ports_bench;
  import iop_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] wdata;
    logic [3:0] rexp;
    logic [1:0] resp;
  } iop_row_s;
  logic        clk, rst;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  sw, ext, clamp, in_pin, bd_in, bd_out, bd_oe_n;
  logic        buz_en, buz_tone, sleep;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        br1, br2, br3, evt, summ, sclr, rise, third, wdog, irq;
  int          err_count, check_count;
  iop_row_s    rows [7];

  // A short tap period keeps the debounce waits brief.
  iop_ports #(.FAST_DIV(4), .USE_SLOW_TAP(1'b0), .READ_BLOCK_WHEN_DRIVING(4'h4), .SLEEP_TRISTATE_OPTION(4'h8))
  u_iop_ports (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
    .INPUT_PIN_IN(in_pin), .BIDIR_PIN_IN(bd_in), .BIDIR_PIN_OUT(bd_out), .BIDIR_PIN_OE_N_OUT(bd_oe_n),
    .BUZZER_ENABLE_IN(buz_en), .BUZZER_TONE_IN(buz_tone), .SLEEP_IN(sleep),
    .BRANCH_TEST_ONE_OUT(br1), .BRANCH_TEST_TWO_OUT(br2), .BRANCH_TEST_THREE_OUT(br3),
    .EVENT_COUNTER_PIN_OUT(evt), .INPUT_GROUP_SUMMARY_OUT(summ), .SUMMARY_CLEAR_OUT(sclr),
    .RISING_EDGE_SELECT_OUT(rise), .THIRD_DEBOUNCE_BYPASS_OUT(third), .WATCHDOG_DISABLE_OUT(wdog),
    .IRQ_OUT(irq)
  );

  iop_pin_partner u_iop_pin_partner (
    .switch_level_in(sw), .ext_drive_in(ext), .clamp_low_in(clamp), .pin_drive_in(bd_out),
    .pin_oe_n_in(bd_oe_n), .input_pin_out(in_pin), .bidir_pin_out(bd_in)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    err_count++;
    summarize();
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Handshakes are judged at the falling edge, where ready and valid are settled for the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] er);
    int         n;
    logic       a_t, w_t, b_t;
    logic [1:0] rsp;
    @(posedge clk);
    awaddr <= a;
    wdata <= {28'h000_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    n = 0;
    while (!b_t && n < 40) begin
      @(negedge clk);
      a_t = awready & awvalid;
      w_t = wready & wvalid;
      b_t = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (a_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_t) tmo();
    chk(34'(rsp), 34'(er));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [3:0] e, input logic [1:0] er);
    int          n;
    logic        a_t, r_t, clr;
    logic [33:0] got;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    n = 0;
    while (!r_t && n < 40) begin
      @(negedge clk);
      a_t = arready & arvalid;
      r_t = rvalid;
      got = {rresp, rdata};
      clr = sclr;
      @(posedge clk);
      if (a_t) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_t) tmo();
    chk(got, {er, 28'h000_0000, e});
    chk(34'(clr), 34'(a == OFF_IN_IRQ_REQ));
  endtask

  task automatic pins(input logic [3:0] v);
    @(posedge clk);
    sw <= v;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    tmo();
  end

  initial begin
    rst = 1'b1;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = '0;
    sw = 4'h0;
    ext = 4'h9;
    clamp = 4'h0;
    {buz_en, buz_tone, sleep} = 3'h0;
    err_count = 0;
    check_count = 0;
    rows[0] = '{OFF_OPTION, 4'hF, 4'hF, RESP_OKAY};
    rows[1] = '{OFF_OPTION, 4'h0, 4'h0, RESP_OKAY};
    rows[2] = '{OFF_IN_IRQ_MASK, 4'hA, 4'hA, RESP_OKAY};
    rows[3] = '{OFF_BIDIR_DIR, 4'h5, 4'h5, RESP_OKAY};
    rows[4] = '{OFF_IN_IRQ_REQ, 4'hF, 4'h0, RESP_OKAY};
    rows[5] = '{OFF_INT_MASK, 4'h3, 4'h3, RESP_OKAY};
    rows[6] = '{8'h20, 4'hF, 4'h0, RESP_SLVERR};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk(34'({bd_oe_n, irq, summ, wdog, rise, third, br1, evt}), 34'({4'hF, 7'h00}));
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].resp);
      rdc(rows[i].addr, rows[i].rexp, rows[i].resp);
    end
    wr(OFF_OPTION, 4'hF, RESP_OKAY);
    wt(1);
    chk(34'({rise, third, wdog}), 34'(3'h7));
    wr(OFF_OPTION, 4'h0, RESP_OKAY);
    // Branch outputs must ignore a change until two tap ticks agree, and a one-cycle glitch entirely.
    pins(4'h7);
    wt(4);
    chk(34'({br3, br2, br1}), 34'(3'h0));
    wt(20);
    chk(34'({br3, br2, br1}), 34'(3'h7));
    pins(4'h5);
    pins(4'h7);
    wt(20);
    chk(34'(br2), 34'(1'b1));
    pins(4'hA);
    wt(4);
    rdc(OFF_IN_STATUS, 4'hA, RESP_OKAY);
    chk(34'(evt), 34'(1'b1));
    wr(OFF_OPTION, 4'h2, RESP_OKAY);
    wr(OFF_IN_IRQ_MASK, 4'h5, RESP_OKAY);
    pins(4'hF);
    wt(6);
    rdc(OFF_IN_IRQ_REQ, 4'h0, RESP_OKAY);
    pins(4'hC);
    wt(4);
    chk(34'(summ), 34'(1'b1));
    rdc(OFF_IN_IRQ_REQ, 4'h1, RESP_OKAY);
    wt(1);
    chk(34'(summ), 34'(1'b0));
    rdc(OFF_IN_IRQ_REQ, 4'h0, RESP_OKAY);
    wr(OFF_OPTION, 4'h8, RESP_OKAY);
    wt(30);
    pins(4'hF);
    wt(4);
    chk(34'(summ), 34'(1'b0));
    wt(30);
    rdc(OFF_IN_IRQ_REQ, 4'h1, RESP_OKAY);
    chk(34'(irq), 34'(1'b1));
    wr(OFF_INT_MASK, 4'h0, RESP_OKAY);
    wt(2);
    chk(34'(irq), 34'(1'b0));
    rdc(OFF_INT_STATUS, 4'h1, RESP_OKAY);
    wr(OFF_INT_STATUS, 4'hF, RESP_OKAY);
    wr(OFF_INT_MASK, 4'hF, RESP_OKAY);
    wt(2);
    chk(34'(irq), 34'(1'b0));
    rdc(OFF_INT_STATUS, 4'h0, RESP_OKAY);
    // Pins 1 and 2 are clamped low while driven, so only the blocked pin reads its latch.
    wr(OFF_BIDIR_DATA, 4'h6, RESP_OKAY);
    wr(OFF_BIDIR_DIR, 4'hE, RESP_OKAY);
    @(posedge clk);
    clamp <= 4'h6;
    wt(3);
    chk(34'({bd_oe_n, bd_out[3:1]}), 34'({4'h1, 3'h3}));
    rdc(OFF_BIDIR_DATA, 4'h5, RESP_OKAY);
    @(posedge clk);
    sleep <= 1'b1;
    wt(3);
    chk(34'(bd_oe_n), 34'(4'h9));
    @(posedge clk);
    sleep <= 1'b0;
    buz_en <= 1'b1;
    buz_tone <= 1'b1;
    wt(3);
    chk(34'({bd_oe_n[0], bd_out[0]}), 34'(2'h1));
    @(posedge clk);
    buz_tone <= 1'b0;
    wt(3);
    chk(34'(bd_out[0]), 34'(1'b0));
    @(posedge clk);
    buz_en <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk(34'(bd_oe_n), 34'(4'hF));
    rdc(OFF_BIDIR_DIR, 4'h0, RESP_OKAY);
    rdc(OFF_IN_IRQ_MASK, 4'h0, RESP_OKAY);
    rdc(OFF_OPTION, 4'h0, RESP_OKAY);
    summarize();
  end
endmodule // iop_ports_bench
